// ==== design/serial_flash_command_decoder.sv ====
// Serial flash command decoder: takes one-byte instructions from the link and runs them.
// Assumes an external array that answers mem_addr_out combinationally on mem_data_in.
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
module serial_flash_command_decoder #(
	parameter int unsigned STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLES,
	parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
	parameter int unsigned SECTOR_ERASE_CYCLES = `SECTOR_ERASE_CYCLES,
	parameter int unsigned CHIP_ERASE_CYCLES = `CHIP_ERASE_CYCLES,
	// Arbitrary value.
	parameter logic [7:0] MAKER_ID = 8'h5e,
	// Arbitrary value.
	parameter logic [7:0] MEM_TYPE_ID = 8'h31,
	// Arbitrary value.
	parameter logic [7:0] DEVICE_ID = 8'h07
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic sclk_in,
	input wire logic sel_n_in,
	input wire logic sio0_in,
	output logic sio0_out,
	output logic sio0_oe_out,
	output logic so_out,
	output logic so_oe_out,
	input wire logic [7:0] mem_data_in,
	output logic [15:0] mem_addr_out,
	output logic prog_wr_out,
	output logic [15:0] prog_addr_out,
	output logic [7:0] prog_data_out,
	output logic erase_out,
	output var flash_pkg::erase_kind_t erase_kind_out,
	output logic [15:0] erase_addr_out,
	output logic [7:0] status_out,
	output logic deep_sleep_out
);
	import flash_pkg::*;

	// ====================================================================
	// Decoding helpers
	function automatic logic is_known(input logic [7:0] op);
		return op inside {`OP_WRITE_ENABLE, `OP_WRITE_DISABLE, `OP_READ_IDENT,
			`OP_READ_STATUS, `OP_WRITE_STATUS, `OP_READ, `OP_FAST_READ,
			`OP_PARAM_TABLE, `OP_DUAL_READ, `OP_SECTOR_ERASE, `OP_BLOCK_ERASE_A,
			`OP_BLOCK_ERASE_B, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B,
			`OP_PAGE_PROGRAM, `OP_DEEP_SLEEP, `OP_SIG_READ, `OP_MAKER_DEVICE_ID};
	endfunction

	function automatic logic takes_addr(input logic [7:0] op);
		return op inside {`OP_READ, `OP_FAST_READ, `OP_PARAM_TABLE, `OP_DUAL_READ,
			`OP_SECTOR_ERASE, `OP_BLOCK_ERASE_A, `OP_BLOCK_ERASE_B,
			`OP_PAGE_PROGRAM, `OP_SIG_READ, `OP_MAKER_DEVICE_ID};
	endfunction

	function automatic logic needs_latch(input logic [7:0] op);
		return op inside {`OP_WRITE_STATUS, `OP_SECTOR_ERASE, `OP_BLOCK_ERASE_A,
			`OP_BLOCK_ERASE_B, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B, `OP_PAGE_PROGRAM};
	endfunction

	function automatic logic is_erase(input logic [7:0] op);
		return op inside {`OP_SECTOR_ERASE, `OP_BLOCK_ERASE_A, `OP_BLOCK_ERASE_B,
			`OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B};
	endfunction

	// Table header carries an ASCII signature; the rest of the table reads erased.
	function automatic logic [7:0] param_byte(input logic [7:0] a);
		unique case (a)
			8'h00: return 8'h53;
			8'h01: return 8'h46;
			8'h02: return 8'h44;
			8'h03: return 8'h50;
			default: return 8'hff;
		endcase
	endfunction

	// ====================================================================
	// Link sampling
	link_if lk();

	link_sampler sampler (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.sclk_in(sclk_in),
		.sel_n_in(sel_n_in),
		.si_in(sio0_in),
		.lk(lk.sampler)
	);

	// ====================================================================
	// State and decode wires
	link_state_t state;
	engine_state_t eng;
	logic [7:0] cmd;
	logic [7:0] shreg;
	logic [2:0] bit_cnt;
	logic [1:0] addr_cnt;
	logic [23:0] addr;
	logic wr_complete;
	logic [7:0] wsr_data;
	logic [8:0] pb_cnt;
	logic [8:0] eng_idx;
	logic [31:0] timer;
	logic [2:0] out_cnt;
	logic [7:0] out_shift;
	logic [1:0] out_idx;
	logic [7:0] page_buf [0:`PAGE_BYTES-1];

	logic [7:0] rx_byte;
	logic byte_done;
	logic cmd_byte;
	logic op_ok;
	logic addr_done;
	logic exec;
	logic deep_release;
	logic pb_write;
	logic [7:0] pb_wptr;
	logic [7:0] pb_rptr;
	logic dual;
	logic out_last;
	logic tx_load;
	logic [7:0] id_byte;
	logic [7:0] pair_byte;
	logic [7:0] tx_byte;
	logic [31:0] busy_cycles;

	assign rx_byte = {shreg[6:0], lk.si_bit};
	assign byte_done = lk.sclk_rise && (bit_cnt == 3'h7) && !lk.sel_rise && !lk.sel_fall;
	assign cmd_byte = byte_done && (state == ST_CMD);
	assign op_ok = is_known(rx_byte)
		&& (!deep_sleep_out || rx_byte == `OP_SIG_READ)
		&& (!status_out[`SR_BUSY_BIT] || rx_byte == `OP_READ_STATUS)
		&& (!needs_latch(rx_byte) || status_out[`SR_LATCH_BIT]);
	assign addr_done = byte_done && (state == ST_ADDR) && (addr_cnt == 2'h2);
	// Modifying work starts only when select rises on a whole byte.
	assign exec = lk.sel_rise && (state == ST_WDATA) && wr_complete && (bit_cnt == 3'h0)
		&& (eng == ENG_IDLE);
	// Release on the bare opcode, or once the signature read has begun.
	assign deep_release = lk.sel_rise && (cmd == `OP_SIG_READ) && (bit_cnt == 3'h0)
		&& ((state == ST_ADDR && addr_cnt == 2'h0) || state == ST_RDATA);
	assign pb_write = byte_done && (state == ST_WDATA) && (cmd == `OP_PAGE_PROGRAM);
	assign pb_wptr = addr[7:0] + pb_cnt[7:0];
	assign pb_rptr = addr[7:0] + eng_idx[7:0];
	assign busy_cycles = (cmd == `OP_WRITE_STATUS) ? STATUS_WRITE_CYCLES :
		(cmd == `OP_PAGE_PROGRAM) ? PROG_CYCLES :
		(cmd == `OP_SECTOR_ERASE) ? SECTOR_ERASE_CYCLES : CHIP_ERASE_CYCLES;

	// ====================================================================
	// Instruction framing
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			state <= ST_IDLE;
			cmd <= 8'h00;
			shreg <= 8'h00;
			bit_cnt <= 3'h0;
			addr_cnt <= 2'h0;
			addr <= 24'h000000;
			wr_complete <= 1'b0;
			wsr_data <= 8'h00;
		end else if (lk.sel_rise) begin
			state <= ST_IDLE;
		end else if (lk.sel_fall) begin
			state <= ST_CMD;
			bit_cnt <= 3'h0;
			wr_complete <= 1'b0;
		end else if (lk.sclk_rise && state != ST_IDLE && state != ST_IGNORE) begin
			shreg <= rx_byte;
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				unique case (state)
					ST_CMD: begin
						cmd <= rx_byte;
						addr_cnt <= 2'h0;
						if (!op_ok) begin
							state <= ST_IGNORE;
						end else if (takes_addr(rx_byte)) begin
							state <= ST_ADDR;
						end else if (rx_byte == `OP_READ_STATUS || rx_byte == `OP_READ_IDENT) begin
							state <= ST_RDATA;
						end else begin
							state <= ST_WDATA;
							wr_complete <= (rx_byte != `OP_WRITE_STATUS);
						end
					end
					ST_ADDR: begin
						addr <= {addr[15:0], rx_byte};
						addr_cnt <= addr_cnt + 2'h1;
						if (addr_cnt == 2'h2) begin
							if (cmd == `OP_FAST_READ || cmd == `OP_PARAM_TABLE) begin
								state <= ST_DUMMY;
							end else if (needs_latch(cmd)) begin
								state <= ST_WDATA;
								wr_complete <= (cmd != `OP_PAGE_PROGRAM);
							end else begin
								state <= ST_RDATA;
							end
						end
					end
					ST_DUMMY: begin
						state <= ST_RDATA;
					end
					ST_WDATA: begin
						wsr_data <= rx_byte;
						wr_complete <= 1'b1;
					end
					default: begin
						state <= state;
					end
				endcase
			end
		end
	end

	// A page longer than the buffer stops the count at 256, so each later byte overwrites the slot at the start address.
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in || lk.sel_fall) begin
			pb_cnt <= 9'h000;
		end else if (pb_write) begin
			pb_cnt <= (pb_cnt == 9'h100) ? pb_cnt : pb_cnt + 9'h001;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (pb_write) begin
			page_buf[pb_wptr] <= rx_byte;
		end
	end

	// ====================================================================
	// Output shifting
	assign dual = (cmd == `OP_DUAL_READ);
	assign out_last = dual ? (out_cnt == 3'h3) : (out_cnt == 3'h7);
	assign tx_load = (state == ST_RDATA) && lk.sclk_fall && !lk.sel_rise && (out_cnt == 3'h0);
	assign id_byte = (out_idx == 2'h0) ? MAKER_ID : (out_idx == 2'h1) ? MEM_TYPE_ID : DEVICE_ID;
	assign pair_byte = (out_idx[0] ^ addr[0]) ? DEVICE_ID : MAKER_ID;
	assign tx_byte = (cmd == `OP_READ_STATUS) ? status_out :
		(cmd == `OP_READ_IDENT) ? id_byte :
		(cmd == `OP_SIG_READ) ? DEVICE_ID :
		(cmd == `OP_MAKER_DEVICE_ID) ? pair_byte :
		(cmd == `OP_PARAM_TABLE) ? param_byte(mem_addr_out[7:0]) : mem_data_in;

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			so_out <= 1'b0;
			sio0_out <= 1'b0;
			so_oe_out <= 1'b0;
			sio0_oe_out <= 1'b0;
			out_cnt <= 3'h0;
			out_shift <= 8'h00;
			out_idx <= 2'h0;
		end else if (state != ST_RDATA || lk.sel_rise) begin
			so_oe_out <= 1'b0;
			sio0_oe_out <= 1'b0;
			out_cnt <= 3'h0;
			out_idx <= 2'h0;
		end else if (lk.sclk_fall) begin
			out_cnt <= out_last ? 3'h0 : out_cnt + 3'h1;
			so_oe_out <= 1'b1;
			sio0_oe_out <= dual;
			if (out_cnt == 3'h0) begin
				so_out <= tx_byte[7];
				sio0_out <= tx_byte[6];
				out_shift <= dual ? {tx_byte[5:0], 2'h0} : {tx_byte[6:0], 1'b0};
				out_idx <= (cmd == `OP_READ_IDENT && out_idx == 2'h2) ? 2'h0 : out_idx + 2'h1;
			end else begin
				so_out <= out_shift[7];
				sio0_out <= out_shift[6];
				out_shift <= dual ? {out_shift[5:0], 2'h0} : {out_shift[6:0], 1'b0};
			end
		end
	end

	// Reads stream on through the whole array and wrap at the top.
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			mem_addr_out <= 16'h0000;
		end else if (addr_done) begin
			mem_addr_out <= {addr[7:0], rx_byte};
		end else if (tx_load) begin
			mem_addr_out <= mem_addr_out + 16'h0001;
		end
	end

	// ====================================================================
	// Status and write engine
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			status_out <= `SR_RESET;
			deep_sleep_out <= 1'b0;
			eng <= ENG_IDLE;
			timer <= 32'h0;
			eng_idx <= 9'h000;
			erase_out <= 1'b0;
			erase_kind_out <= ERASE_SECTOR;
			erase_addr_out <= 16'h0000;
			prog_wr_out <= 1'b0;
			prog_addr_out <= 16'h0000;
			prog_data_out <= 8'h00;
		end else begin
			erase_out <= 1'b0;
			prog_wr_out <= 1'b0;
			if (deep_release) begin
				deep_sleep_out <= 1'b0;
			end
			unique case (eng)
				ENG_IDLE: begin
					if (exec) begin
						if (cmd == `OP_WRITE_ENABLE) begin
							status_out[`SR_LATCH_BIT] <= 1'b1;
						end
						if (cmd == `OP_WRITE_DISABLE) begin
							status_out[`SR_LATCH_BIT] <= 1'b0;
						end
						if (cmd == `OP_DEEP_SLEEP) begin
							deep_sleep_out <= 1'b1;
						end
						if (cmd == `OP_WRITE_STATUS) begin
							status_out <= (status_out & ~`SR_WRITE_MASK)
								| (wsr_data & `SR_WRITE_MASK);
						end
						if (needs_latch(cmd)) begin
							status_out[`SR_BUSY_BIT] <= 1'b1;
							timer <= busy_cycles;
							eng_idx <= 9'h000;
							eng <= (cmd == `OP_PAGE_PROGRAM) ? ENG_PROG : ENG_WAIT;
						end
						if (is_erase(cmd)) begin
							erase_out <= 1'b1;
							if (cmd == `OP_SECTOR_ERASE) begin
								erase_kind_out <= ERASE_SECTOR;
								erase_addr_out <= addr[15:0] & `SECTOR_BASE_MASK;
							end else begin
								// This array is one block, so block erase clears it all.
								erase_kind_out <= (cmd == `OP_CHIP_ERASE_A || cmd == `OP_CHIP_ERASE_B)
									? ERASE_CHIP : ERASE_BLOCK;
								erase_addr_out <= 16'h0000;
							end
						end
					end
				end
				ENG_PROG: begin
					prog_wr_out <= 1'b1;
					prog_addr_out <= {addr[15:8], pb_rptr};
					prog_data_out <= page_buf[pb_rptr];
					eng_idx <= eng_idx + 9'h001;
					if (eng_idx + 9'h001 == pb_cnt) begin
						eng <= ENG_WAIT;
					end
				end
				ENG_WAIT: begin
					if (timer == 32'h0) begin
						status_out[`SR_BUSY_BIT] <= 1'b0;
						status_out[`SR_LATCH_BIT] <= 1'b0;
						eng <= ENG_IDLE;
					end else begin
						timer <= timer - 32'h1;
					end
				end
				default: begin
					eng <= ENG_IDLE;
				end
			endcase
		end
	end

	// ====================================================================
	// Checks
	default clocking chk_clk @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);

	a_enable_sets_latch: assert property (exec && cmd == `OP_WRITE_ENABLE |=> status_out[1])
		else $error("write enable did not set the latch");
	a_status_shift_out: assert property (tx_load && cmd == `OP_READ_STATUS
		|=> so_out == $past(status_out[7]) && so_oe_out)
		else $error("status byte not shifted out");
	a_status_write_loads: assert property (exec && cmd == `OP_WRITE_STATUS
		|=> status_out[7] == $past(wsr_data[7]) && status_out[0])
		else $error("status write did not load bits");
	a_sector_base_addr: assert property (erase_out && erase_kind_out == ERASE_SECTOR
		|-> erase_addr_out[11:0] == 12'h000)
		else $error("sector erase not on a sector base");
	a_standby_output_off: assert property (cmd_byte && !op_ok
		|=> state == ST_IGNORE ##1 !so_oe_out && !sio0_oe_out)
		else $error("unknown opcode did not go to standby");
	a_boundary_reject: assert property (lk.sel_rise && bit_cnt != 3'h0 && eng == ENG_IDLE
		|=> eng == ENG_IDLE && !erase_out && $stable(status_out))
		else $error("partial byte instruction executed");
	a_busy_blocks_array: assert property (cmd_byte && status_out[0]
		&& rx_byte != `OP_READ_STATUS |=> state == ST_IGNORE)
		else $error("instruction taken while busy");
	a_latch_refuses: assert property (cmd_byte && !status_out[1] && needs_latch(rx_byte)
		|=> state == ST_IGNORE)
		else $error("modifying instruction taken without latch");
	a_cycle_end_clears: assert property (eng == ENG_WAIT && timer == 32'h0
		|=> status_out[1:0] == 2'h0 && eng == ENG_IDLE)
		else $error("finished cycle left busy or latch set");
	a_sleep_ignores: assert property (cmd_byte && deep_sleep_out
		&& rx_byte != `OP_SIG_READ |=> state == ST_IGNORE)
		else $error("deep sleep accepted an instruction");
endmodule
`default_nettype wire

// ==== design/flash_consts.svh ====
// Constants of the serial flash command decoder: opcodes, status fields, timing.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH

// ====================================================================
// Opcodes
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_IDENT 8'h9f
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_PARAM_TABLE 8'h5a
`define OP_DUAL_READ 8'h3b
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE_A 8'h52
`define OP_BLOCK_ERASE_B 8'hd8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hc7
`define OP_PAGE_PROGRAM 8'h02
`define OP_DEEP_SLEEP 8'hb9
`define OP_SIG_READ 8'hab
`define OP_MAKER_DEVICE_ID 8'h90

// ====================================================================
// Status register layout
`define SR_SRWD_BIT 7
`define SR_BP1_BIT 3
`define SR_BP0_BIT 2
`define SR_LATCH_BIT 1
`define SR_BUSY_BIT 0
`define SR_WRITE_MASK 8'h8c
`define SR_RESET 8'h00

// ====================================================================
// Array layout
`define SECTOR_BASE_MASK 16'hf000
`define PAGE_BYTES 256

// ====================================================================
// Timing
`define CLK_MHZ 25
`define STATUS_WRITE_TIME_US 10
`define PROG_TIME_US 3000
`define SECTOR_ERASE_TIME_US 40000
`define CHIP_ERASE_TIME_US 2000000
`define STATUS_WRITE_CYCLES (`STATUS_WRITE_TIME_US * `CLK_MHZ)
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define SECTOR_ERASE_CYCLES (`SECTOR_ERASE_TIME_US * `CLK_MHZ)
`define CHIP_ERASE_CYCLES (`CHIP_ERASE_TIME_US * `CLK_MHZ)

`endif

// ==== design/flash_pkg.sv ====
// Types shared by the serial flash command decoder.
// Assumes nothing of its surroundings.
package flash_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ADDR = 3'b010,
		ST_DUMMY = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101,
		ST_IGNORE = 3'b110
	} link_state_t;
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_PROG = 2'b01,
		ENG_WAIT = 2'b10
	} engine_state_t;
	typedef enum logic [1:0] {
		ERASE_SECTOR = 2'b00,
		ERASE_BLOCK = 2'b01,
		ERASE_CHIP = 2'b10
	} erase_kind_t;
endpackage

// ==== design/link_if.sv ====
// Sampled link events passed from the pin sampler to the decoder core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface link_if;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_fall;
	logic sel_rise;
	logic si_bit;
	modport sampler (output sclk_rise, sclk_fall, sel_fall, sel_rise, si_bit);
	modport core (input sclk_rise, sclk_fall, sel_fall, sel_rise, si_bit);
endinterface
`default_nettype wire

// ==== design/link_sampler.sv ====
// Synchronises the serial clock, select and data pins and finds the clock and select edges.
// Assumes the serial clock runs well below a quarter of the system clock.
`timescale 1ns/1ps
`default_nettype none
module link_sampler (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic sclk_in,
	input wire logic sel_n_in,
	input wire logic si_in,
	link_if.sampler lk
);
	logic [2:0] sclk_q;
	logic [2:0] sel_q;
	logic [1:0] si_q;

	// Data runs through the same depth as the clock, so a rise sees the bit that it latched.
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			sclk_q <= 3'h0;
			sel_q <= 3'h7;
			si_q <= 2'h0;
		end else begin
			sclk_q <= {sclk_q[1:0], sclk_in};
			sel_q <= {sel_q[1:0], sel_n_in};
			si_q <= {si_q[0], si_in};
		end
	end

	assign lk.sclk_rise = sclk_q[1] & ~sclk_q[2];
	assign lk.sclk_fall = ~sclk_q[1] & sclk_q[2];
	assign lk.sel_fall = ~sel_q[1] & sel_q[2];
	assign lk.sel_rise = sel_q[1] & ~sel_q[2];
	assign lk.si_bit = si_q[1];
endmodule
`default_nettype wire

// ==== verification/spi_host_model.sv ====
// Host model that drives the serial link of the flash command decoder.
// Assumes the decoder's clock runs eight times faster than the link clock.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic clk_in,
	input wire logic so_in,
	input wire logic so_oe_in,
	input wire logic sio0_in,
	output logic sclk_out,
	output logic sel_n_out,
	output logic sio0_out
);
	logic [7:0] rxq[$];
	logic seen_oe;
	// ====================================================================
	// Bit and frame tasks
	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		sio0_out = 1'b0;
		seen_oe = 1'b0;
	end
	// Data changes on the fall and is sampled just before the rise.
	task automatic bitx(input logic b, output logic [1:0] r);
		sclk_out <= 1'b0;
		sio0_out <= b;
		repeat (5) @(posedge clk_in);
		r = {so_in, sio0_in};
		seen_oe = seen_oe | so_oe_in;
		sclk_out <= 1'b1;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic frame(input logic m3, input logic [47:0] tx, input int ntx, input int nrx,
		input int xb, input logic dual);
		logic [1:0] r;
		logic [7:0] d;
		rxq = {};
		seen_oe = 1'b0;
		sclk_out <= m3;
		repeat (4) @(posedge clk_in);
		sel_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		for (int i = 0; i < ntx * 8; i++) begin
			bitx(tx[ntx * 8 - 1 - i], r);
		end
		for (int j = 0; j < nrx; j++) begin
			for (int k = 0; k < (dual ? 4 : 8); k++) begin
				bitx(k[0], r);
				d = dual ? {d[5:0], r} : {d[6:0], r[1]};
			end
			rxq.push_back(d);
		end
		for (int i = 0; i < xb; i++) begin
			bitx(1'b1, r);
		end
		// Select rises with the clock back at idle, off a boundary only when xb asks.
		sclk_out <= m3;
		repeat (5) @(posedge clk_in);
		sel_n_out <= 1'b1;
		// A released line must not keep its last value, or a stale bit could pass.
		repeat (8) begin
			@(posedge clk_in);
			sio0_out <= ~sio0_out;
		end
	endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the serial flash command decoder.
// Assumes a combinational array model and shortened program and erase cycle counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import flash_pkg::*;
	typedef struct packed {
		logic [47:0] tx;
		logic [2:0] ntx;
		logic [2:0] nrx;
		logic [31:0] rx;
	} row_t;
	localparam int LIMIT = 40000;
	localparam logic [31:0] OPS = 32'h52d860c7;
	localparam row_t ROWS [8] = '{
		'{48'h9f, 3'd1, 3'd3, 32'h5e3107},
		'{48'h05, 3'd1, 3'd1, 32'h0},
		'{48'h03123456, 3'd4, 3'd2, 32'h6263},
		'{48'h0b00010200, 3'd5, 3'd1, 32'h03},
		'{48'h90000001, 3'd4, 3'd2, 32'h075e},
		'{48'h90000000, 3'd4, 3'd2, 32'h5e07},
		'{48'hab000000, 3'd4, 3'd1, 32'h07},
		'{48'h5a00000000, 3'd5, 3'd4, 32'h53464450}
	};
	logic ref_clk_in, resetn_in, sclk, sel_n, host_sio0, sio0_w, so_w;
	logic dut_sio0, dut_sio0_oe, so, so_oe, prog_wr, erase, deep_sleep;
	logic [7:0] mem_data, prog_data, status;
	logic [15:0] mem_addr, prog_addr, erase_addr, e_addr;
	erase_kind_t erase_kind, e_kind;
	logic [23:0] pq[$];
	int n_fail = 0, checks = 0, cyc = 0, n_erase = 0;
	// ====================================================================
	// Clock, wiring and monitors
	initial begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	assign sio0_w = dut_sio0_oe ? dut_sio0 : host_sio0;
	// A released output shows the inverse of its last bit, so a stale bit cannot pass.
	assign so_w = so_oe ? so : ~so;
	assign mem_data = mem_addr[15:8] ^ mem_addr[7:0];
	serial_flash_command_decoder #(.STATUS_WRITE_CYCLES(400), .PROG_CYCLES(1000),
		.SECTOR_ERASE_CYCLES(2000), .CHIP_ERASE_CYCLES(1000)) i_serial_flash_command_decoder (
		.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .sclk_in(sclk), .sel_n_in(sel_n),
		.sio0_in(sio0_w), .sio0_out(dut_sio0), .sio0_oe_out(dut_sio0_oe), .so_out(so),
		.so_oe_out(so_oe), .mem_data_in(mem_data), .mem_addr_out(mem_addr),
		.prog_wr_out(prog_wr), .prog_addr_out(prog_addr), .prog_data_out(prog_data),
		.erase_out(erase), .erase_kind_out(erase_kind), .erase_addr_out(erase_addr),
		.status_out(status), .deep_sleep_out(deep_sleep));
	spi_host_model i_spi_host_model (.clk_in(ref_clk_in), .so_in(so_w), .so_oe_in(so_oe),
		.sio0_in(sio0_w), .sclk_out(sclk), .sel_n_out(sel_n), .sio0_out(host_sio0));
	always @(posedge ref_clk_in) begin
		if (erase) begin
			n_erase++;
			e_kind = erase_kind;
			e_addr = erase_addr;
		end
		if (prog_wr) pq.push_back({prog_addr, prog_data});
		cyc++;
		if (cyc == LIMIT) begin
			n_fail++;
			tally_and_finish();
		end
	end
	// ====================================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic fr(input logic m3, input logic [47:0] tx, input int ntx, input int nrx,
		input int xb = 0, input logic dual = 1'b0);
		i_spi_host_model.frame(m3, tx, ntx, nrx, xb, dual);
	endtask
	// Polling status before going on keeps the host polite while a cycle runs.
	task automatic wait_ready;
		for (int i = 0; i < 40; i++) begin
			fr(1'b0, 48'h05, 1, 1);
			if (i_spi_host_model.rxq[0][0] === 1'b0) break;
		end
		chk(status[0], 0);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ====================================================================
	// Main sequence
	initial begin
		logic [7:0] op;
		resetn_in <= 1'b0;
		repeat (16) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		chk({so_oe, deep_sleep, status}, 0);
		for (int i = 0; i < 8; i++) begin
			fr(i[0], ROWS[i].tx, ROWS[i].ntx, ROWS[i].nrx);
			for (int j = 0; j < ROWS[i].nrx; j++) begin
				chk(i_spi_host_model.rxq[j], ROWS[i].rx[8 * (ROWS[i].nrx - 1 - j) +: 8]);
			end
		end
		fr(1'b0, 48'h020012feaa, 5, 0);
		chk(pq.size(), 0);
		fr(1'b0, 48'h06, 1, 0);
		chk(status[1], 1);
		fr(1'b1, 48'h04, 1, 0);
		chk(status[1], 0);
		fr(1'b0, 48'h06, 1, 0);
		fr(1'b1, 48'h20001000, 4, 0, 3);
		chk({n_erase[7:0], status}, 16'h0002);
		fr(1'b1, 48'h20005abc, 4, 0);
		chk({n_erase[7:0], e_kind, e_addr}, {8'd1, ERASE_SECTOR, 16'h5000});
		chk(status, 8'h03);
		fr(1'b0, 48'h03001000, 4, 1);
		chk(i_spi_host_model.seen_oe, 0);
		wait_ready();
		chk(status, 0);
		fr(1'b0, 48'h06, 1, 0);
		fr(1'b0, 48'h020012ffaabb, 6, 0);
		wait_ready();
		chk(pq.size(), 2);
		chk(pq[0], 24'h12ffaa);
		chk(pq[1], 24'h1200bb);
		for (int k = 0; k < 4; k++) begin
			op = OPS[31 - 8 * k -: 8];
			fr(1'b0, 48'h06, 1, 0);
			fr(1'b1, k < 2 ? {op, 24'h003000} : 48'(op), k < 2 ? 4 : 1, 0);
			chk({n_erase[7:0], e_kind, e_addr}, {8'(2 + k), k < 2 ? ERASE_BLOCK : ERASE_CHIP, 16'h0});
			wait_ready();
		end
		fr(1'b0, 48'h3b000010, 4, 1, 0, 1'b1);
		chk(i_spi_host_model.rxq[0], 8'h10);
		fr(1'b0, 48'hff, 1, 1);
		chk(i_spi_host_model.seen_oe, 0);
		fr(1'b1, 48'h03000000, 4, 0, 3);
		fr(1'b0, 48'h05, 1, 1);
		chk(i_spi_host_model.rxq[0], 0);
		fr(1'b0, 48'hb9, 1, 0);
		chk(deep_sleep, 1);
		fr(1'b1, 48'h9f, 1, 1);
		chk(i_spi_host_model.seen_oe, 0);
		fr(1'b0, 48'hab, 1, 0);
		chk(deep_sleep, 0);
		fr(1'b0, 48'h06, 1, 0);
		fr(1'b1, 48'h01ff, 2, 0);
		chk(status[0], 1);
		wait_ready();
		chk(status, 8'h8c);
		tally_and_finish();
	end
endmodule
`default_nettype wire
